// File: core/isp_pkg.sv
/*
 Shared constants and carrier types for the ISA slave port that serves the boot PROM,
 the shared SRAM and the configuration data port.
 Assumes a 200 MHz system clock; private bus timing is built from 50 ns periods.
*/
package isp_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 5;
   localparam int unsigned PRIV_PERIOD_NS = 50;
   localparam int unsigned PRIV_TICKS     = (PRIV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SRAM_RD_PERIODS = 2;
   localparam int unsigned SRAM_WR_PERIODS = 3;
   localparam int unsigned PROM_PERIODS    = 3;
   localparam logic [4:0]  RD_LEN   = 5'(SRAM_RD_PERIODS * PRIV_TICKS);
   localparam logic [4:0]  WR_LEN   = 5'(SRAM_WR_PERIODS * PRIV_TICKS);
   localparam logic [4:0]  PROM_LEN = 5'(PROM_PERIODS * PRIV_TICKS);
   // Write strobe starts after the first falling edge, ends after the third
   localparam logic [4:0]  WE_ON    = 5'(PRIV_TICKS / 2);
   localparam logic [4:0]  WE_OFF   = 5'((SRAM_WR_PERIODS - 1) * PRIV_TICKS + PRIV_TICKS / 2);

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] SD_RST    = 16'h0000;
   localparam logic [15:0] ADDR_RST  = 16'h0000;
   localparam logic [7:0]  INDEX_RST = 8'h00;
   localparam logic [4:0]  TICK_RST  = 5'h00;

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      I_IDLE = 3'b000,
      I_PROM = 3'b001,
      I_SRD  = 3'b010,
      I_SWR  = 3'b011,
      I_HOLD = 3'b100
   } isp_isa_st_t;

   typedef enum logic [1:0] {
      E_IDLE = 2'b00,
      E_SRD  = 2'b01,
      E_SWR  = 2'b10,
      E_PROM = 2'b11
   } isp_eng_st_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] sa;
      logic        sbhe_n;
      logic        memr_n;
      logic        memw_n;
      logic        ref_n;
      logic        memcs16_n;
      logic        aen;
      logic        ior_n;
      logic        iow_n;
   } isp_isa_in_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  data;
      logic        data_oe;
      logic        boot_prom_select_n;
      logic        sram_output_enable_n;
      logic        sram_write_enable_n;
   } isp_prv_out_t;

endpackage

// File: core/isp_port.sv
/*
 ISA bus slave port: boot PROM and shared SRAM memory cycles with write posting,
 word prefetch and ready stretching, plus the register index and config data ports.
 Assumes external decode drives the match inputs and MEMCS16, an arbiter grants
 the private bus, and the configuration word for the latched index arrives on
 cfg_read_data. All inputs are synchronous to sys_clk.
*/
// Overview of operation
// - Config read: write index to register index port, then read config data port
// - Boot PROM is an 8-bit part on the private bus, 64 Kbyte space
// - boot_prom_wide_cycles set selects 16-bit PROM cycles when MEMCS16 is asserted, clear selects 8-bit
// - Wide PROM read: stretch ready, fetch two bytes, drive word, hold till MEMR ends
// - Without SBHE ever seen since reset, every cycle is 8-bit
// - PROM select is low for exactly three 50 ns periods
// - SRAM cycles assumed 16-bit; board asserts MEMCS16 for them
// - SRAM access starts on REF inactive, command, match and, once SBHE is seen, MEMCS16; AEN ignored
// - SRAM writes are posted in a holding register and written later
// - New write while posting register full stretches ready until drained
// - SRAM read stretches ready while the prefetch buffer does not hold the word
// - Prefetch tag mismatch: stretch ready, read two SRAM bytes, then as a hit
// - Hit drives buffered word, releases ready, prefetches again after MEMR ends
// - Prefetches run between ISA cycles at successive word addresses
// - Any other private bus activity invalidates the prefetched word
// - SRAM read spans two periods, output enable throughout, sample at end
// - SRAM write spans three periods, strobe from first to third falling edge
`timescale 1ns/10ps
module isp_port
(
   input  wire logic                  sys_clk,
   input  wire logic                  sys_rst,
   input  wire isp_pkg::isp_isa_in_t  isa,
   input  wire logic [15:0]           sd_in,
   input  wire logic                  boot_prom_match_n,
   input  wire logic                  shared_memory_match_n,
   input  wire logic                  boot_prom_wide_cycles,
   input  wire logic                  register_index_port_sel,
   input  wire logic                  config_data_port_sel,
   input  wire logic [15:0]           cfg_read_data,
   input  wire logic                  prv_bus_gnt,
   input  wire logic                  net_prv_activity,
   input  wire logic [7:0]            private_data_bus_in,
   output logic [15:0]                sd_out,
   output logic                       sd_oe_lo,
   output logic                       sd_oe_hi,
   output logic                       iochrdy_o,
   output logic                       iochrdy_oe,
   output logic                       prv_bus_req,
   output logic [7:0]                 cfg_index,
   output isp_pkg::isp_prv_out_t      prv
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] lane_byte(input logic [15:0] w, input logic hi);
      lane_byte = hi ? w[15:8] : w[7:0];
   endfunction

   isp_pkg::isp_isa_st_t ist_q;
   isp_pkg::isp_eng_st_t est_q;
   logic        sbhe_seen_q;
   logic        post_valid_q;
   logic [15:0] post_addr_q;
   logic [15:0] post_data_q;
   logic        post_two_q;
   logic        pf_valid_q;
   logic        pf_stale_q;
   logic [14:0] pf_tag_q;
   logic [15:0] pf_data_q;
   logic        pf_want_q;
   logic [14:0] pf_next_q;
   logic        prom_req_q;
   logic        prom_two_q;
   logic        prom_done_q;
   logic [15:0] prom_data_q;
   logic [15:0] job_addr_q;
   logic        job_two_q;
   logic        byte_q;
   logic [4:0]  tick_q;
   logic [7:0]  rd_lo_q;
   logic        was_read_q;

   logic wide, cmd_free, prom_cyc, sram_rd, sram_wr, pf_hit, post_take;
   logic dem_req, job_end, job_last, srd_done, swr_done, eng_start;

   // Byte enables steer a 16-bit cycle only once SBHE has shown life
   assign wide     = sbhe_seen_q && !isa.memcs16_n;
   assign cmd_free = isa.memr_n && isa.memw_n && isa.ior_n && isa.iow_n;
   assign prom_cyc = isa.ref_n && !boot_prom_match_n && !isa.memr_n;
   // AEN is deliberately not looked at for memory cycles
   assign sram_rd  = isa.ref_n && !shared_memory_match_n && !isa.memr_n
                     && (!isa.memcs16_n || !sbhe_seen_q);
   assign sram_wr  = isa.ref_n && !shared_memory_match_n && !isa.memw_n
                     && (!isa.memcs16_n || !sbhe_seen_q);
   assign pf_hit   = pf_valid_q && (pf_tag_q == isa.sa[15:1]);
   assign post_take = !post_valid_q && ((ist_q == isp_pkg::I_IDLE && sram_wr)
                      || ist_q == isp_pkg::I_SWR);
   assign dem_req  = (ist_q == isp_pkg::I_SRD) && !pf_hit;
   assign job_end  = (est_q == isp_pkg::E_SRD && tick_q == isp_pkg::RD_LEN)
                  || (est_q == isp_pkg::E_SWR && tick_q == isp_pkg::WR_LEN)
                  || (est_q == isp_pkg::E_PROM && tick_q == isp_pkg::PROM_LEN);
   assign job_last = job_end && (byte_q == job_two_q);
   assign srd_done = job_last && (est_q == isp_pkg::E_SRD);
   assign swr_done = job_last && (est_q == isp_pkg::E_SWR);
   assign eng_start = (est_q == isp_pkg::E_IDLE) && prv_bus_gnt
                      && (prom_req_q || post_valid_q || dem_req || pf_want_q);

   // ----------------------------------------------------------------
   // Width detection
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         sbhe_seen_q <= 1'b0;
      else if (!isa.sbhe_n)
         sbhe_seen_q <= 1'b1;
   end

   // ----------------------------------------------------------------
   // ISA cycle sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ist_q      <= isp_pkg::I_IDLE;
         sd_out     <= isp_pkg::SD_RST;
         sd_oe_lo   <= 1'b0;
         sd_oe_hi   <= 1'b0;
         iochrdy_oe <= 1'b0;
         cfg_index  <= isp_pkg::INDEX_RST;
         prom_req_q <= 1'b0;
         prom_two_q <= 1'b0;
         was_read_q <= 1'b0;
      end
      else
      begin
         if (eng_start && prom_req_q)
            prom_req_q <= 1'b0;
         case (ist_q)
            isp_pkg::I_IDLE:
            begin
               sd_oe_lo   <= 1'b0;
               sd_oe_hi   <= 1'b0;
               iochrdy_oe <= 1'b0;
               was_read_q <= 1'b0;
               if (prom_cyc)
               begin
                  ist_q      <= isp_pkg::I_PROM;
                  iochrdy_oe <= 1'b1;
                  prom_req_q <= 1'b1;
                  prom_two_q <= boot_prom_wide_cycles && wide;
               end
               else if (sram_rd)
               begin
                  ist_q      <= isp_pkg::I_SRD;
                  iochrdy_oe <= !pf_hit;
               end
               else if (sram_wr)
               begin
                  // A full holding register stalls the bus, not the data
                  ist_q      <= post_valid_q ? isp_pkg::I_SWR : isp_pkg::I_HOLD;
                  iochrdy_oe <= post_valid_q;
               end
               else if (!isa.aen && register_index_port_sel && !isa.iow_n)
               begin
                  cfg_index <= sd_in[7:0];
                  ist_q     <= isp_pkg::I_HOLD;
               end
               else if (!isa.aen && config_data_port_sel && !isa.ior_n)
               begin
                  sd_out   <= cfg_read_data;
                  sd_oe_lo <= 1'b1;
                  sd_oe_hi <= wide;
                  ist_q    <= isp_pkg::I_HOLD;
               end
            end
            isp_pkg::I_SWR:
            begin
               if (!post_valid_q)
               begin
                  iochrdy_oe <= 1'b0;
                  ist_q      <= isp_pkg::I_HOLD;
               end
            end
            isp_pkg::I_SRD:
            begin
               iochrdy_oe <= !pf_hit;
               if (pf_hit)
               begin
                  if (wide)
                  begin
                     sd_out   <= pf_data_q;
                     sd_oe_lo <= !isa.sa[0];
                     sd_oe_hi <= !isa.sbhe_n;
                  end
                  else
                  begin
                     sd_out   <= {8'h00, lane_byte(pf_data_q, isa.sa[0])};
                     sd_oe_lo <= 1'b1;
                  end
                  was_read_q <= 1'b1;
                  ist_q      <= isp_pkg::I_HOLD;
               end
            end
            isp_pkg::I_PROM:
            begin
               if (prom_done_q)
               begin
                  iochrdy_oe <= 1'b0;
                  if (prom_two_q)
                  begin
                     sd_out   <= prom_data_q;
                     sd_oe_lo <= 1'b1;
                     sd_oe_hi <= 1'b1;
                  end
                  else
                  begin
                     sd_out   <= {8'h00, prom_data_q[7:0]};
                     sd_oe_lo <= 1'b1;
                  end
                  ist_q <= isp_pkg::I_HOLD;
               end
            end
            isp_pkg::I_HOLD:
            begin
               if (cmd_free)
               begin
                  sd_oe_lo <= 1'b0;
                  sd_oe_hi <= 1'b0;
                  ist_q    <= isp_pkg::I_IDLE;
               end
            end
            default:
               ist_q <= isp_pkg::I_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Write posting
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         post_valid_q <= 1'b0;
         post_addr_q  <= isp_pkg::ADDR_RST;
         post_data_q  <= isp_pkg::SD_RST;
         post_two_q   <= 1'b0;
      end
      else if (post_take)
      begin
         post_valid_q <= 1'b1;
         post_two_q   <= wide && !isa.sbhe_n && !isa.sa[0];
         post_addr_q  <= isa.sa;
         if (wide && !isa.sbhe_n && !isa.sa[0])
            post_data_q <= sd_in;
         else
            post_data_q <= {8'h00, lane_byte(sd_in, wide && isa.sa[0])};
      end
      else if (swr_done)
         post_valid_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Prefetch buffer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pf_valid_q <= 1'b0;
         pf_stale_q <= 1'b0;
         pf_tag_q   <= 15'h0000;
         pf_data_q  <= isp_pkg::SD_RST;
         pf_want_q  <= 1'b0;
         pf_next_q  <= 15'h0000;
      end
      else
      begin
         if (srd_done)
         begin
            pf_data_q  <= {private_data_bus_in, rd_lo_q};
            pf_tag_q   <= job_addr_q[15:1];
            // A write posted mid-fetch may target this word
            pf_valid_q <= !pf_stale_q && !post_take && !net_prv_activity;
            pf_stale_q <= 1'b0;
         end
         else if (post_take || net_prv_activity
                  || (eng_start && (prom_req_q || post_valid_q)))
         begin
            pf_valid_q <= 1'b0;
            // A fetch launched in this same cycle would read the word before the write
            pf_stale_q <= (est_q == isp_pkg::E_SRD)
                          || (eng_start && !prom_req_q && !post_valid_q);
         end
         if (ist_q == isp_pkg::I_SRD && pf_hit)
            pf_next_q <= isa.sa[15:1] + 15'h0001;
         if (ist_q == isp_pkg::I_HOLD && cmd_free && was_read_q)
            pf_want_q <= 1'b1;
         else if (eng_start && !prom_req_q && !post_valid_q && !dem_req)
            pf_want_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Private bus engine
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         est_q       <= isp_pkg::E_IDLE;
         tick_q      <= isp_pkg::TICK_RST;
         byte_q      <= 1'b0;
         job_addr_q  <= isp_pkg::ADDR_RST;
         job_two_q   <= 1'b0;
         rd_lo_q     <= 8'h00;
         prom_data_q <= isp_pkg::SD_RST;
         prom_done_q <= 1'b0;
         prv_bus_req <= 1'b0;
      end
      else
      begin
         prom_done_q <= 1'b0;
         prv_bus_req <= (est_q != isp_pkg::E_IDLE) || prom_req_q || post_valid_q
                        || dem_req || pf_want_q;
         case (est_q)
            isp_pkg::E_IDLE:
            begin
               tick_q <= isp_pkg::TICK_RST;
               byte_q <= 1'b0;
               if (eng_start)
               begin
                  if (prom_req_q)
                  begin
                     est_q      <= isp_pkg::E_PROM;
                     job_two_q  <= prom_two_q;
                     job_addr_q <= prom_two_q ? {isa.sa[15:1], 1'b0} : isa.sa;
                  end
                  else if (post_valid_q)
                  begin
                     est_q      <= isp_pkg::E_SWR;
                     job_two_q  <= post_two_q;
                     job_addr_q <= post_addr_q;
                  end
                  else
                  begin
                     est_q      <= isp_pkg::E_SRD;
                     job_two_q  <= 1'b1;
                     job_addr_q <= {dem_req ? isa.sa[15:1] : pf_next_q, 1'b0};
                  end
               end
            end
            isp_pkg::E_SRD, isp_pkg::E_SWR, isp_pkg::E_PROM:
            begin
               tick_q <= tick_q + 5'h01;
               if (job_end)
               begin
                  tick_q <= isp_pkg::TICK_RST;
                  byte_q <= 1'b1;
                  if (!byte_q)
                     rd_lo_q <= private_data_bus_in;
                  if (est_q == isp_pkg::E_PROM)
                  begin
                     if (byte_q)
                        prom_data_q[15:8] <= private_data_bus_in;
                     else
                        prom_data_q <= {8'h00, private_data_bus_in};
                  end
                  if (job_last)
                  begin
                     est_q       <= isp_pkg::E_IDLE;
                     prom_done_q <= est_q == isp_pkg::E_PROM;
                  end
               end
            end
            default:
               est_q <= isp_pkg::E_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Private bus pins
   // ----------------------------------------------------------------
   // Strobes lag the engine by one clock; the engine samples one tick late to match
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         prv       <= '{isp_pkg::ADDR_RST, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1};
         iochrdy_o <= 1'b0;
      end
      else
      begin
         iochrdy_o <= 1'b0;
         prv.addr  <= job_addr_q + {15'h0000, byte_q};
         prv.data  <= lane_byte(post_data_q, byte_q);
         prv.data_oe <= (est_q == isp_pkg::E_SWR) && (tick_q < isp_pkg::WR_LEN);
         prv.boot_prom_select_n <= !((est_q == isp_pkg::E_PROM)
                                     && (tick_q < isp_pkg::PROM_LEN));
         prv.sram_output_enable_n <= !((est_q == isp_pkg::E_SRD)
                                       && (tick_q < isp_pkg::RD_LEN));
         prv.sram_write_enable_n <= !((est_q == isp_pkg::E_SWR)
                                      && (tick_q >= isp_pkg::WE_ON)
                                      && (tick_q < isp_pkg::WE_OFF));
      end
   end

endmodule

// File: tb/isp_port_chk.sv
/*
 Checker for the ISA slave port: strobe widths, lanes, ready and bus holds.
 Assumes it is bound to isp_port and sees only that module's ports.
*/
`timescale 1ns/10ps
module isp_port_chk
(
   input wire logic                  sys_clk,
   input wire logic                  sys_rst,
   input wire isp_pkg::isp_isa_in_t  isa,
   input wire logic                  sd_oe_lo,
   input wire logic                  sd_oe_hi,
   input wire logic                  iochrdy_oe,
   input wire isp_pkg::isp_prv_out_t prv
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // ----------------------------------------------------------------
   // Strobe width counters
   // ----------------------------------------------------------------
   logic [5:0] cs_q, oe_q, we_q;
   logic       wide_q;
   always_ff @(posedge sys_clk)
   begin
      cs_q   <= (sys_rst || prv.boot_prom_select_n) ? 6'h00 : cs_q + 6'h01;
      oe_q   <= (sys_rst || prv.sram_output_enable_n) ? 6'h00 : oe_q + 6'h01;
      we_q   <= (sys_rst || prv.sram_write_enable_n) ? 6'h00 : we_q + 6'h01;
      wide_q <= !sys_rst && (wide_q || !isa.sbhe_n);
   end
   sequence cmd_quiet;
      isa.memr_n && isa.memw_n && isa.ior_n && isa.iow_n;
   endsequence
   sequence rd_strobe;
      !prv.sram_output_enable_n ##1 !prv.sram_output_enable_n;
   endsequence
   prom_sel_width_a: assert property ($rose(prv.boot_prom_select_n) |-> cs_q == 6'h1e)
      else $error("boot prom select width wrong");
   sram_rd_width_a: assert property ($rose(prv.sram_output_enable_n) |-> oe_q == 6'h14)
      else $error("sram read strobe width wrong");
   sram_wr_width_a: assert property ($rose(prv.sram_write_enable_n) |-> we_q == 6'h14)
      else $error("sram write strobe width wrong");
   rd_addr_hold_a: assert property (rd_strobe |-> $stable(prv.addr) && !prv.data_oe)
      else $error("sram read address moved");
   wr_data_hold_a: assert property (prv.data_oe ##1 prv.data_oe |-> $stable(prv.data))
      else $error("sram write data moved");
   strobe_excl_a: assert property ($onehot0({!prv.boot_prom_select_n,
      !prv.sram_output_enable_n, !prv.sram_write_enable_n}))
      else $error("private strobes overlap");
   narrow_lane_a: assert property (!wide_q && isa.sbhe_n |-> !sd_oe_hi)
      else $error("high lane driven in narrow system");
   rdy_vs_data_a: assert property (sd_oe_lo || sd_oe_hi |-> !iochrdy_oe)
      else $error("ready held low while data driven");
   data_release_a: assert property (cmd_quiet ##1 cmd_quiet |=> !sd_oe_lo && !sd_oe_hi)
      else $error("data lanes not released");
endmodule
bind isp_port isp_port_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .isa(isa),
   .sd_oe_lo(sd_oe_lo), .sd_oe_hi(sd_oe_hi), .iochrdy_oe(iochrdy_oe), .prv(prv));

// File: tb/isp_prv_mem.sv
/*
 Private bus partner: 64 Kbyte SRAM, boot PROM and a bus arbiter.
 Assumes active-low strobes; the SRAM chip select is tied on by the board. 
*/
`timescale 1ns/10ps
module isp_prv_mem
(
   input  wire logic                  sys_clk,
   input  wire logic                  slow,
   input  wire logic                  req,
   input  wire isp_pkg::isp_prv_out_t prv,
   output logic                       gnt,
   output logic [7:0]                 rd_data
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_q = 8'h00;
   logic [3:0] wait_q = 4'h0;
   initial
   begin
      for (int a = 0; a < 65536; a++)
         mem[a] = 8'(a * 5 + 3);
   end
   // Released bus flips each cycle so a late sample cannot pass by luck
   assign rd_data = !prv.sram_output_enable_n ? mem[prv.addr] :
                    !prv.boot_prom_select_n ? prv.addr[7:0] ^ prv.addr[15:8] ^ 8'h3c :
                    ~last_q;
   always @(posedge sys_clk)
   begin
      last_q <= rd_data;
      wait_q <= req ? wait_q + {3'h0, wait_q != 4'hf} : 4'h0;
      gnt    <= req && (!slow || wait_q == 4'hf);
      if (!prv.sram_write_enable_n)
         mem[prv.addr] <= prv.data;
   end
endmodule

// File: tb/isp_port_test.sv
/*
 Self-checking bench for isp_port with the private bus partner model.
 Assumes a 200 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module isp_port_test;
   logic                  sys_clk = 1'b0;
   logic                  sys_rst = 1'b1;
   isp_pkg::isp_isa_in_t  isa;
   isp_pkg::isp_prv_out_t prv;
   logic [15:0]           sd_in, cfg_rd, sd_out;
   logic                  bpm_n, smm_n, wide, ix_sel, cd_sel, gnt, net, slow;
   logic                  oe_lo, oe_hi, rdy_o, rdy_oe, req;
   logic [7:0]            prd, idx;
   logic [7:0]            ref_mem [int];
   int                    err_count = 0;
   int                    checks = 0;
   logic [31:0]           seed = 32'd99864;
   always #2.5 sys_clk = ~sys_clk;
   isp_port DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .isa(isa), .sd_in(sd_in),
      .boot_prom_match_n(bpm_n), .shared_memory_match_n(smm_n), .boot_prom_wide_cycles(wide),
      .register_index_port_sel(ix_sel), .config_data_port_sel(cd_sel), .cfg_read_data(cfg_rd),
      .prv_bus_gnt(gnt), .net_prv_activity(net), .private_data_bus_in(prd), .sd_out(sd_out),
      .sd_oe_lo(oe_lo), .sd_oe_hi(oe_hi), .iochrdy_o(rdy_o), .iochrdy_oe(rdy_oe),
      .prv_bus_req(req), .cfg_index(idx), .prv(prv));
   isp_prv_mem MEM (.sys_clk(sys_clk), .slow(slow), .req(req), .prv(prv), .gnt(gnt),
      .rd_data(prd));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] mb(int a);
      return ref_mem.exists(a) ? ref_mem[a] : 8'(a * 5 + 3);
   endfunction
   function automatic logic [7:0] pb(logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // ----------------------------------------------------------------
   // One ISA cycle: 0 prom read, 1 sram read, 2 sram write, 3 index, 4 config
   // ----------------------------------------------------------------
   task automatic cyc(int k, logic [15:0] a, wd, logic bh_n, cs_n,
                      output logic [15:0] rd, output logic st);
      int n;
      st = 1'b0;
      n = 0;
      @(posedge sys_clk);
      isa.sa <= a;
      isa.sbhe_n <= bh_n;
      isa.memcs16_n <= cs_n;
      isa.aen <= (k < 3) ? 1'(xs()) : 1'b0;
      bpm_n <= k != 0;
      smm_n <= !(k == 1 || k == 2);
      ix_sel <= k == 3;
      cd_sel <= k == 4;
      sd_in <= wd;
      {isa.memr_n, isa.memw_n, isa.iow_n, isa.ior_n} <= ~(4'h1 << (k < 2 ? 3 : 4 - k));
      do
      begin
         @(posedge sys_clk);
         #1;
         st = st | rdy_oe;
         n++;
      end
      while (n < 150 && ((k == 2 || k == 3) ? (n < 3 || rdy_oe) : !(oe_lo || oe_hi)));
      // A cycle that never drove data hands back unknowns so its compare fails
      rd = (oe_lo || oe_hi) ? sd_out : 16'hxxxx;
      @(posedge sys_clk);
      {isa.memr_n, isa.memw_n, isa.iow_n, isa.ior_n} <= 4'hf;
      {bpm_n, smm_n, ix_sel, cd_sel} <= 4'hc;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      give_verdict();
   end
   initial
   begin
      logic [15:0] r, a, w;
      logic        s;
      int          b;
      isa = '1;
      isa.aen = 1'b0;
      {sd_in, cfg_rd} = 32'h0;
      {bpm_n, smm_n, wide, ix_sel, cd_sel, net, slow} = 7'h60;
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      check("idle", 16'({req, rdy_o, rdy_oe, oe_hi, oe_lo, prv[2:0]}), 16'h0007);
      // Narrow system first: SBHE high and MEMCS16 never asserted
      a = 16'(xs());
      cyc(0, a, 16'h0, 1'b1, 1'b1, r, s);
      check("narrow prom byte", 16'(r[7:0]), 16'(pb(a)));
      a = 16'(xs()) | 16'h0001;
      w = 16'(xs());
      cyc(2, a, w, 1'b1, 1'b1, r, s);
      ref_mem[int'(a)] = w[7:0];
      cyc(1, a, 16'h0, 1'b1, 1'b1, r, s);
      check("narrow sram byte", 16'(r[7:0]), 16'(mb(int'(a))));
      w = 16'(xs());
      cfg_rd <= 16'(xs());
      cyc(3, 16'h0, w, 1'b1, 1'b1, r, s);
      check("index", 16'(idx), 16'(w[7:0]));
      cyc(4, 16'h2, 16'h0, 1'b1, 1'b1, r, s);
      check("config byte", 16'(r[7:0]), 16'(cfg_rd[7:0]));
      // Wide system: board raises MEMCS16 with every match except the refused-lanes read
      for (int m = 0; m < 2; m++)
      begin
         wide <= m[0];
         a = 16'(xs()) & 16'hfffe;
         cyc(0, a, 16'h0, 1'b0, 1'b0, r, s);
         check("prom stretch", 16'(s), 16'h1);
         check("prom data", m ? r : 16'(r[7:0]), m ? {pb(a + 16'h1), pb(a)} : 16'(pb(a)));
      end
      a = 16'(xs()) & 16'hfff0;
      for (int i = 0; i < 2; i++)
      begin
         w = 16'(xs());
         cyc(2, a + 16'(2 * i), w, 1'b0, 1'b0, r, s);
         ref_mem[int'(a) + 2 * i] = w[7:0];
         ref_mem[int'(a) + 2 * i + 1] = w[15:8];
         check("post stretch", 16'(s), 16'(i));
      end
      for (int i = 0; i < 4; i++)
      begin
         net <= i > 1;
         slow <= i == 3;
         @(posedge sys_clk);
         net <= 1'b0;
         b = int'(a) + 2 * i;
         cyc(1, 16'(b), 16'h0, 1'b0, 1'b0, r, s);
         check("sram word", r, {mb(b + 1), mb(b)});
         check("read stretch", 16'(s), 16'(i != 1));
         repeat (80) @(posedge sys_clk);
      end
      cyc(1, a, 16'h0, 1'b0, 1'b1, r, s);
      check("refused lanes", 16'({oe_hi, oe_lo}), 16'h0);
      isa.ref_n <= 1'b0;
      cyc(1, a, 16'h0, 1'b0, 1'b0, r, s);
      isa.ref_n <= 1'b1;
      check("ref refused", 16'({s, oe_hi, oe_lo}), 16'h0);
      check("rest", 16'({req, rdy_o, rdy_oe, oe_hi, oe_lo, prv[2:0]}), 16'h0007);
      give_verdict();
   end
endmodule
